/* File: asrp_pkg.sv */
// shared constants and types for the serial result port
package asrp_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CONV_TIME_US    = 16_600;
  localparam int unsigned CONV_CYC        = CONV_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned REF_START_US    = 12_000;
  localparam int unsigned REF_START_CYC   = REF_START_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RESULT_W        = 16;
  localparam int unsigned CFG_W           = 4;
  localparam int unsigned CNT_W           = 24;
  localparam logic [15:0] MID_CODE        = 16'h8000;
  localparam logic [15:0] FULL_CODE       = 16'hFFFF;
  localparam logic [15:0] ZERO_CODE       = 16'h0000;
  localparam logic        RATE_RST        = 1'b0;
  localparam logic        SLEEP_RST       = 1'b0;
  localparam logic [4:0]  BITS_LAST       = 5'h10;

  typedef enum logic [1:0] {
    ASRP_CONVERT = 2'b00,
    ASRP_NAP     = 2'b01,
    ASRP_XFER    = 2'b11
  } asrp_state_e;
endpackage

/* File: asrp_buf_if.sv */
// result hand-over between converter core and shifter buffer
`timescale 1ns/1ps
interface asrp_buf_if;
  logic        valid;
  logic        ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

/* File: asrp_buf.sv */
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
module asrp_buf #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_b_in,
  input  wire logic         ce_in,
  asrp_buf_if.dst           up,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              rd;
    logic              wr;
    logic [1:0]        cnt;
  } asrp_buf_s;
  asrp_buf_s s_q, s_d;

  assign up.ready      = (s_q.cnt != 2'd2);
  assign out_valid_out = (s_q.cnt != 2'd0);
  assign out_data_out  = s_q.mem[s_q.rd];

  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop  = 1'b0;
    s_d  = s_q;
    push = up.valid && (s_q.cnt != 2'd2);
    pop  = out_ready_in && (s_q.cnt != 2'd0);
    if (push) begin
      s_d.mem[s_q.wr] = up.data;
      s_d.wr          = ~s_q.wr;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  AST_BUF_NO_OVER: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    s_q.cnt <= 2'd2) else $error("buffer count overflow");
endmodule

/* File: asrp_top.sv */
// serial result port of a 16-bit converter: conversion timing, shifter, config
`timescale 1ns/1ps
module asrp_top #(
  parameter bit          DIFF_VARIANT = 1'b0,
  parameter int unsigned CONV_CYCLES  = asrp_pkg::CONV_CYC,
  parameter int unsigned REF_CYCLES   = asrp_pkg::REF_START_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        sck_in,
  input  wire logic        cs_b_in,
  input  wire logic        sdi_in,
  input  wire logic [15:0] sample_code_in,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  output logic             conv_busy_out,
  output logic             ref_on_out,
  output logic             ref_stable_out,
  output logic             rate_select_bit_out,
  output logic             ref_sleep_bit_out,
  output logic             calib_on_out,
  output logic             slow_rate_out,
  output logic             sample_ack_out
);
  typedef struct packed {
    logic [1:0]             sck_s;
    logic [1:0]             cs_s;
    logic [1:0]             sdi_s;
    logic                   sck_p;
    logic                   cs_p;
    asrp_pkg::asrp_state_e  st;
    logic [asrp_pkg::CNT_W-1:0] cnt;
    logic [asrp_pkg::CNT_W-1:0] ref_cnt;
    logic                   ref_on;
    logic                   sleep_armed;
    logic                   rate;
    logic                   sleep;
    logic [3:0]             cfg;
    logic [4:0]             rbits;
    logic [4:0]             tbits;
    logic [15:0]            shreg;
    logic                   sdo;
    logic                   tied_hi;
    logic                   tied_lo;
    logic                   take;
  } asrp_s;
  asrp_s s_q, s_d;

  asrp_buf_if bif ();
  logic        buf_valid;
  logic [15:0] buf_data;
  logic        core_valid;
  logic        core_done;

  asrp_buf #(
    .W (asrp_pkg::RESULT_W)
  ) u_buf (
    .clk_sys_in    (clk_sys_in),
    .rst_b_in      (rst_b_in),
    .ce_in         (ce_in),
    .up            (bif.dst),
    .out_valid_out (buf_valid),
    .out_ready_in  (s_q.take),
    .out_data_out  (buf_data)
  );

  // pass-through: full scale, zero and every other code return unchanged; analog front end supplies the raw code
  function automatic logic [15:0] clamp_code(input logic [15:0] c);
    if (c == asrp_pkg::FULL_CODE) begin
      clamp_code = asrp_pkg::FULL_CODE;
    end else if (c == asrp_pkg::ZERO_CODE) begin
      clamp_code = asrp_pkg::ZERO_CODE;
    end else begin
      clamp_code = c;
    end
  endfunction

  function automatic logic [asrp_pkg::CNT_W-1:0] conv_len(input logic slow);
    if (slow) begin
      conv_len = asrp_pkg::CNT_W'(2 * CONV_CYCLES);
    end else begin
      conv_len = asrp_pkg::CNT_W'(CONV_CYCLES);
    end
  endfunction

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic cs_low;
  logic slow;
  assign sck_rise = s_q.sck_s[1] & ~s_q.sck_p;
  assign sck_fall = ~s_q.sck_s[1] & s_q.sck_p;
  assign cs_rise  = s_q.cs_s[1] & ~s_q.cs_p;
  assign cs_fall  = ~s_q.cs_s[1] & s_q.cs_p;
  assign cs_low   = ~s_q.cs_s[1];
  assign slow     = ~DIFF_VARIANT & s_q.rate;

  assign core_valid = (s_q.st == asrp_pkg::ASRP_CONVERT) && (s_q.cnt == '0);
  assign core_done  = core_valid && bif.ready;
  assign bif.valid  = core_valid;
  assign bif.data   = clamp_code(sample_code_in);

  always_comb begin
    s_d          = s_q;
    s_d.sck_s    = {s_q.sck_s[0], sck_in};
    s_d.cs_s     = {s_q.cs_s[0], cs_b_in};
    s_d.sdi_s    = {s_q.sdi_s[0], sdi_in};
    s_d.sck_p    = s_q.sck_s[1];
    s_d.cs_p     = s_q.cs_s[1];
    s_d.take     = 1'b0;
    if (s_q.ref_cnt != '0) begin
      s_d.ref_cnt = s_q.ref_cnt - 1'b1;
    end
    case (s_q.st)
      asrp_pkg::ASRP_CONVERT: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else if (core_done) begin
          s_d.st = asrp_pkg::ASRP_NAP;
          if (s_q.sleep_armed) begin
            s_d.ref_on = 1'b0;
          end
        end
        s_d.sdo = 1'b1;
      end
      asrp_pkg::ASRP_NAP: begin
        s_d.sdo = 1'b0;
        if (cs_low && buf_valid) begin
          s_d.st    = asrp_pkg::ASRP_XFER;
          s_d.shreg = buf_data;
          s_d.sdo   = buf_data[15];
          s_d.take  = 1'b1;
          s_d.rbits = '0;
          s_d.tbits = '0;
          s_d.tied_hi = 1'b1;
          s_d.tied_lo = 1'b1;
          if (!s_q.ref_on) begin
            s_d.ref_on  = 1'b1;
            s_d.ref_cnt = asrp_pkg::CNT_W'(REF_CYCLES);
          end
        end
      end
      asrp_pkg::ASRP_XFER: begin
        if (sck_rise) begin
          s_d.rbits = s_q.rbits + 5'd1;
          if (s_q.rbits < 5'(asrp_pkg::CFG_W)) begin
            s_d.cfg = {s_q.cfg[2:0], s_q.sdi_s[1]};
          end
          s_d.tied_hi = s_q.tied_hi & s_q.sdi_s[1];
          s_d.tied_lo = s_q.tied_lo & ~s_q.sdi_s[1];
        end
        if (sck_fall) begin
          s_d.tbits = s_q.tbits + 5'd1;
          s_d.shreg = {s_q.shreg[14:0], 1'b0};
          s_d.sdo   = s_q.shreg[14];
        end
        if (cs_rise || (sck_fall && s_q.tbits == asrp_pkg::BITS_LAST - 5'd1)
            || (sck_fall && s_q.rbits >= asrp_pkg::BITS_LAST)) begin
          s_d.st  = asrp_pkg::ASRP_CONVERT;
          s_d.cnt = conv_len(slow);
          s_d.sdo = 1'b1;
          if (s_q.rbits >= 5'(asrp_pkg::CFG_W) && s_q.cfg[3] && !s_q.cfg[2]) begin
            s_d.rate  = s_q.cfg[1];
            s_d.sleep = s_q.cfg[0];
            s_d.cnt   = conv_len(~DIFF_VARIANT & s_q.cfg[1]);
          end else if (s_q.rbits >= asrp_pkg::BITS_LAST && s_q.tied_hi) begin
            s_d.rate  = 1'b1;
            s_d.cnt   = conv_len(~DIFF_VARIANT);
          end else if (s_q.rbits >= asrp_pkg::BITS_LAST && s_q.tied_lo) begin
            s_d.rate  = 1'b0;
            s_d.cnt   = conv_len(1'b0);
          end
          s_d.sleep_armed = (s_q.rbits >= 5'(asrp_pkg::CFG_W) && s_q.cfg[3]
                             && !s_q.cfg[2]) ? s_q.cfg[0] : s_q.sleep;
          if (s_q.tied_hi && s_q.rbits >= asrp_pkg::BITS_LAST) begin
            s_d.sleep_armed = 1'b0;
          end
        end
      end
      default: begin
        s_d.st = asrp_pkg::ASRP_CONVERT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q             <= '0;
      s_q.sck_s       <= 2'b00;
      s_q.cs_s        <= 2'b11;
      s_q.cs_p        <= 1'b1;
      s_q.st          <= asrp_pkg::ASRP_CONVERT;
      s_q.cnt         <= asrp_pkg::CNT_W'(CONV_CYCLES);
      s_q.ref_on      <= 1'b1;
      s_q.ref_cnt     <= asrp_pkg::CNT_W'(REF_CYCLES);
      s_q.rate        <= asrp_pkg::RATE_RST;
      s_q.sleep       <= asrp_pkg::SLEEP_RST;
      s_q.sleep_armed <= asrp_pkg::SLEEP_RST;
      s_q.sdo         <= 1'b1;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign sdo_out             = s_q.sdo;
  assign sdo_oe_out          = ~s_q.cs_s[1];
  assign conv_busy_out       = (s_q.st == asrp_pkg::ASRP_CONVERT);
  assign ref_on_out          = s_q.ref_on;
  assign ref_stable_out      = s_q.ref_on && (s_q.ref_cnt == '0);
  assign rate_select_bit_out = s_q.rate;
  assign ref_sleep_bit_out   = s_q.sleep;
  assign calib_on_out        = DIFF_VARIANT | s_q.rate;
  assign slow_rate_out       = slow;
  assign sample_ack_out      = core_done;

  sequence xfer_start;
    s_q.st == asrp_pkg::ASRP_NAP && cs_low && buf_valid;
  endsequence

  // transfer ending with a valid key pair in the first four bits
  sequence keyed_end;
    s_q.st == asrp_pkg::ASRP_XFER && s_d.st == asrp_pkg::ASRP_CONVERT
    && s_q.rbits >= 5'(asrp_pkg::CFG_W) && s_q.cfg[3] && !s_q.cfg[2];
  endsequence

  AST_MSB_FIRST: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (ce_in and xfer_start) |=> s_q.sdo == $past(buf_data[15]))
    else $error("msb not presented at select low");
  AST_SHIFT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ce_in && s_q.st == asrp_pkg::ASRP_XFER && sck_fall && !cs_rise
    && s_q.tbits != 5'd15 && s_q.rbits < 5'd16
    |=> s_q.sdo == $past(s_q.shreg[14]))
    else $error("output did not advance on falling edge");
  AST_ABORT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ce_in && s_q.st == asrp_pkg::ASRP_XFER && cs_rise
    |=> s_q.st == asrp_pkg::ASRP_CONVERT)
    else $error("select rise did not abort");
  AST_END16: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ce_in && s_q.st == asrp_pkg::ASRP_XFER && sck_fall && s_q.tbits == 5'd15
    |=> s_q.st == asrp_pkg::ASRP_CONVERT)
    else $error("16th falling edge did not start conversion");
  AST_KEY: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ce_in && s_q.st == asrp_pkg::ASRP_XFER && s_d.st == asrp_pkg::ASRP_CONVERT
    && !(s_q.cfg[3] && !s_q.cfg[2]) && s_q.rbits < 5'd16
    |=> s_q.rate == $past(s_q.rate))
    else $error("config changed without key");
  AST_STATUS: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    s_q.st == asrp_pkg::ASRP_CONVERT && s_q.cnt != '0 |-> s_q.sdo)
    else $error("status not high during conversion");
  AST_REF_WAKE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ((ce_in && !s_q.ref_on) and xfer_start) |=> s_q.ref_on && s_q.ref_cnt != '0)
    else $error("reference not restarted");
  AST_NAP: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ce_in && core_done |=> s_q.st == asrp_pkg::ASRP_NAP)
    else $error("no nap after conversion");
  AST_DIFF_RATE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    DIFF_VARIANT |-> !slow_rate_out)
    else $error("differential variant ran slow");
  AST_CFG_APPLY: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (ce_in and keyed_end)
    |=> s_q.rate == $past(s_q.cfg[1]) && s_q.sleep == $past(s_q.cfg[0]))
    else $error("keyed config not applied");
  AST_CFG_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ce_in && s_q.st == asrp_pkg::ASRP_XFER && s_q.rbits >= 5'(asrp_pkg::CFG_W)
    |=> s_q.cfg == $past(s_q.cfg))
    else $error("input bit taken after the fourth");
  AST_REF_DOWN: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ce_in && core_done && s_q.sleep_armed |=> !s_q.ref_on)
    else $error("reference not powered down after conversion");
  AST_TIED_SLEEP: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ce_in && s_q.st == asrp_pkg::ASRP_XFER && s_d.st == asrp_pkg::ASRP_CONVERT
    && s_q.tied_hi && s_q.rbits >= asrp_pkg::BITS_LAST |=> !s_q.sleep_armed)
    else $error("sleep left armed with input tied high");
  AST_TIED_LOW: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ce_in && s_q.st == asrp_pkg::ASRP_XFER && s_d.st == asrp_pkg::ASRP_CONVERT
    && s_q.tied_lo && s_q.rbits >= asrp_pkg::BITS_LAST |=> !s_q.rate)
    else $error("rate not cleared with input tied low");
endmodule

/* File: asrp_host.sv */
// host model that masters the serial link of the result port
`timescale 1ns/1ps
module asrp_host (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output logic      sck_out,
  output logic      cs_b_out,
  output logic      sdi_out
);
  initial begin
    sck_out  = 1'b0;
    cs_b_out = 1'b1;
    sdi_out  = 1'b0;
  end

  // set select and idle clock level, then let the device see them
  task automatic pins(input logic cs_b, input logic sck);
    @(negedge clk_in);
    cs_b_out = cs_b;
    sck_out  = sck;
    repeat (6) @(negedge clk_in);
  endtask

  // sixteen clocks from idle low, din msb first, 200 ns period
  task automatic xfer(input logic [15:0] din, output logic [15:0] dout);
    for (int i = 15; i >= 0; i--) begin
      sdi_out = din[i];
      repeat (4) @(negedge clk_in);
      sck_out = 1'b1;
      repeat (4) @(negedge clk_in);
      // bit taken at the rise stands until the fall
      dout[i] = sdo_in;
      sck_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
  endtask
endmodule

/* File: asrp_top_bench.sv */
// self-checking bench for the serial result port
`timescale 1ns/1ps
module asrp_top_bench;
  logic        clk_sys_in  = 1'b0;
  logic        rst_b_in    = 1'b0;
  logic [15:0] sample_code = 16'ha5c3;
  logic        sck;
  logic        cs_b;
  logic        sdi;
  logic        sdo;
  logic        busy;
  logic        ref_on;
  logic        ref_ok;
  logic        rate;
  logic        sleep;
  logic        calib;
  logic        slow;
  logic        oe;
  logic        ack;
  logic [15:0] rd;
  int          fails     = 0;
  int          cmp_count = 0;
  int          acks      = 0;
  wire  [5:0]  st        = {busy, ref_on, rate, sleep, calib, slow};

  always #12.5 clk_sys_in = ~clk_sys_in;

  asrp_top #(.DIFF_VARIANT(1'b0), .CONV_CYCLES(200), .REF_CYCLES(100)) uut (
    .clk_sys_in          (clk_sys_in),
    .rst_b_in            (rst_b_in),
    .ce_in               (1'b1),
    .sck_in              (sck),
    .cs_b_in             (cs_b),
    .sdi_in              (sdi),
    .sample_code_in      (sample_code),
    .sdo_out             (sdo),
    .sdo_oe_out          (oe),
    .conv_busy_out       (busy),
    .ref_on_out          (ref_on),
    .ref_stable_out      (ref_ok),
    .rate_select_bit_out (rate),
    .ref_sleep_bit_out   (sleep),
    .calib_on_out        (calib),
    .slow_rate_out       (slow),
    .sample_ack_out      (ack)
  );

  // count result hand-overs, one per finished conversion
  always @(negedge clk_sys_in) begin
    if (ack === 1'b1) begin
      acks++;
    end
  end

  asrp_host host (
    .clk_in   (clk_sys_in),
    .sdo_in   (sdo),
    .sck_out  (sck),
    .cs_b_out (cs_b),
    .sdi_out  (sdi)
  );

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait on busy or on reference stable
  task automatic wait_for(input bit on_ref, input logic val, input int lim);
    int n;
    n = 0;
    while (((on_ref ? ref_ok : busy) !== val) && n < lim) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= lim) begin
      chk({15'h0000, ~val}, {15'h0000, val});
      give_verdict();
    end
  endtask

  task automatic s_reset();
    repeat (6) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    @(negedge clk_sys_in);
    chk(st, 6'b11_0000);
    wait_for(1'b0, 1'b0, 260);
  endtask

  task automatic s_read_cfg();
    sample_code = 16'h7001;
    host.pins(1'b0, 1'b0);
    chk({oe, sdo}, 2'b11);
    host.xfer(16'hb400, rd);
    chk(rd, 16'ha5c3);
    repeat (3) @(negedge clk_sys_in);
    chk(st, 6'b11_1111);
    host.pins(1'b1, 1'b0);
    chk(oe, 1'b0);
  endtask

  task automatic s_sleep_abort();
    wait_for(1'b0, 1'b0, 500);
    repeat (4) @(negedge clk_sys_in);
    chk(st, 6'b00_1111);
    host.pins(1'b0, 1'b0);
    chk({sdo, ref_on, ref_ok}, 3'b010);
    wait_for(1'b1, 1'b1, 150);
    sample_code = 16'h0ff0;
    host.pins(1'b1, 1'b0);
    chk(busy, 1'b1);
  endtask

  task automatic s_status();
    host.pins(1'b0, 1'b1);
    chk(sdo, 1'b1);
    wait_for(1'b0, 1'b0, 500);
    repeat (6) @(negedge clk_sys_in);
    chk(sdo, 1'b0);
    sample_code = 16'hffff;
    host.pins(1'b1, 1'b1);
    chk(busy, 1'b1);
    host.pins(1'b1, 1'b0);
  endtask

  task automatic s_bad_key();
    wait_for(1'b0, 1'b0, 500);
    host.pins(1'b0, 1'b0);
    chk(sdo, 1'b1);
    sample_code = 16'h0000;
    host.xfer(16'hc800, rd);
    chk(rd, 16'hffff);
    repeat (3) @(negedge clk_sys_in);
    chk(st, 6'b11_1111);
    host.pins(1'b1, 1'b0);
  endtask

  task automatic s_tied_high();
    wait_for(1'b0, 1'b0, 500);
    host.pins(1'b0, 1'b0);
    host.xfer(16'hffff, rd);
    chk(rd, 16'h0000);
    sample_code = 16'h8001;
    repeat (3) @(negedge clk_sys_in);
    chk(st, 6'b11_1111);
    host.pins(1'b1, 1'b0);
    // halved rate: still converting past the base length
    repeat (300) @(negedge clk_sys_in);
    chk(busy, 1'b1);
    wait_for(1'b0, 1'b0, 200);
    chk(ref_on, 1'b1);
  endtask

  task automatic s_tied_low();
    host.pins(1'b0, 1'b0);
    chk({oe, sdo}, 2'b11);
    host.xfer(16'h0000, rd);
    chk(rd, 16'h8001);
    repeat (3) @(negedge clk_sys_in);
    chk(st, 6'b11_0100);
    host.pins(1'b1, 1'b0);
    chk(oe, 1'b0);
    wait_for(1'b0, 1'b0, 260);
    chk(16'(acks), 16'd7);
  endtask

  initial begin
    s_reset();
    s_read_cfg();
    s_sleep_abort();
    s_status();
    s_bad_key();
    s_tied_high();
    s_tied_low();
    give_verdict();
  end
endmodule
